// ===== design/gpio_pkg.sv
// Notes on behaviour
// - Latches A-D at indices 0-3, directions A-D at indices 4-7.
// - Widths A4 B6 C2 D7; unimplemented upper bits read as zero.
// - Reset clears direction bits; data latches keep their value.
// - Port C is two bidirectional pins with pullups only when input.
// - Port C pin direction follows its direction bit; latch is read/write.
// - Port D bits 4-5 go to timer only when edge/level bits select it.
// - Serial pins D0-D3 are general I/O while serial enable is clear.
// - Slave-select pin D0 is general I/O while serial is master.
// - Port D direction bits ignored for pin drive on serial-owned pins.
// - Port D direction bit always picks latch or pin on read.
// - With serial enabled, port B bit-0 direction has no effect on slave select.
// - Port D pullup only while direction bit is input, even on serial- or timer-owned pins; off when bit is output.
// - Pullup enable one connects the pullup, zero disconnects it.
package gpio_pkg;
  localparam int A_W = 4;
  localparam int B_W = 6;
  localparam int C_W = 2;
  localparam int D_W = 7;
  localparam int DATA_W = 8;
  localparam int IDX_W = 6;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PORT_A_LATCH = 6'h00;
  localparam logic [IDX_W-1:0] IDX_PORT_B_LATCH = 6'h01;
  localparam logic [IDX_W-1:0] IDX_PORT_C_LATCH = 6'h02;
  localparam logic [IDX_W-1:0] IDX_PORT_D_LATCH = 6'h03;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DIRECTION = 6'h05;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIRECTION = 6'h06;
  localparam logic [IDX_W-1:0] IDX_PORT_D_DIRECTION = 6'h07;
  localparam logic [IDX_W-1:0] IDX_PORT_D_PULLUP_ENABLE = 6'h08;
  localparam logic [IDX_W-1:0] IDX_PORT_C_PULLUP_ENABLE = 6'h09;
  localparam logic [DATA_W-1:0] DIRECTION_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PULLUP_RESET = 8'h00;
  // Port D bit positions of shared functions
  localparam int D_SS_BIT = 0;
  localparam int D_SPI_LO = 0;
  localparam int D_SPI_HI = 3;
  localparam int D_TIM_LO = 4;
  localparam int D_TIM_HI = 5;
  localparam int PIN_TOTAL = A_W + B_W + C_W + D_W;
endpackage : gpio_pkg

// ===== design/gpio_ports.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_ports
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [A_W-1:0] port_a_pin_i,
  output logic [A_W-1:0] port_a_pin_o,
  output logic [A_W-1:0] port_a_pin_oe_n_o,
  input wire logic [B_W-1:0] port_b_pin_i,
  output logic [B_W-1:0] port_b_pin_o,
  output logic [B_W-1:0] port_b_pin_oe_n_o,
  input wire logic [C_W-1:0] port_c_pin_i,
  output logic [C_W-1:0] port_c_pin_o,
  output logic [C_W-1:0] port_c_pin_oe_n_o,
  output logic [C_W-1:0] port_c_pullup_o,
  input wire logic [D_W-1:0] port_d_pin_i,
  output logic [D_W-1:0] port_d_pin_o,
  output logic [D_W-1:0] port_d_pin_oe_n_o,
  output logic [D_W-1:0] port_d_pullup_o,
  input wire logic serial_if_enable_i,
  input wire logic serial_if_master_select_i,
  input wire logic [3:0] serial_if_pin_out_i,
  input wire logic [3:0] serial_if_pin_oe_n_i,
  output logic [3:0] serial_if_pin_in_o,
  input wire logic [1:0] timer_edge_level_hi_i,
  input wire logic [1:0] timer_edge_level_lo_i,
  input wire logic [1:0] timer_pin_out_i,
  input wire logic [1:0] timer_pin_oe_n_i,
  output logic [1:0] timer_pin_in_o
);

  function automatic logic [DATA_W-1:0] read_mux(input logic [DATA_W-1:0] dir,
                                                 input logic [DATA_W-1:0] lat,
                                                 input logic [DATA_W-1:0] pin);
    read_mux = (dir & lat) | (~dir & pin);
  endfunction : read_mux

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wr,
                                              input logic [DATA_W-1:0] mask);
    merge = (old & ~mask) | (wr & mask);
  endfunction : merge

  // Pin synchronisers; stage one feeds stage two only
  logic [PIN_TOTAL-1:0] sync1_r;
  logic [PIN_TOTAL-1:0] sync2_r;
  logic [DATA_W-1:0] pa_s;
  logic [DATA_W-1:0] pb_s;
  logic [DATA_W-1:0] pc_s;
  logic [DATA_W-1:0] pd_s;

  always_ff @(posedge clk_i) begin
    sync1_r <= {port_d_pin_i, port_c_pin_i, port_b_pin_i, port_a_pin_i};
    sync2_r <= sync1_r;
  end

  assign pa_s = {{(DATA_W-A_W){1'b0}}, sync2_r[A_W-1:0]};
  assign pb_s = {{(DATA_W-B_W){1'b0}}, sync2_r[A_W+B_W-1:A_W]};
  assign pc_s = {{(DATA_W-C_W){1'b0}}, sync2_r[A_W+B_W+C_W-1:A_W+B_W]};
  assign pd_s = {{(DATA_W-D_W){1'b0}}, sync2_r[PIN_TOTAL-1:A_W+B_W+C_W]};

  // Latches have no reset; direction and pullup registers do
  logic [DATA_W-1:0] lat_a_r, lat_b_r, lat_c_r, lat_d_r;
  logic [DATA_W-1:0] lat_a_nxt, lat_b_nxt, lat_c_nxt, lat_d_nxt;
  logic [DATA_W-1:0] dir_a_r, dir_b_r, dir_c_r, dir_d_r;
  logic [DATA_W-1:0] dir_a_nxt, dir_b_nxt, dir_c_nxt, dir_d_nxt;
  logic [DATA_W-1:0] pue_d_r, pue_c_r;
  logic [DATA_W-1:0] pue_d_nxt, pue_c_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;

  logic req;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] rd;

  assign req = cyc_i & stb_i & ~ack_r;
  assign wr = req & we_i & sel_i[0];
  assign idx = adr_i[7:2];
  assign wd = dat_i[DATA_W-1:0];

  localparam logic [DATA_W-1:0] MASK_A = 8'h0f;
  localparam logic [DATA_W-1:0] MASK_B = 8'h3f;
  localparam logic [DATA_W-1:0] MASK_C = 8'h03;
  localparam logic [DATA_W-1:0] MASK_D = 8'h7f;

  always_comb begin
    rd = 8'h00;
    case (idx)
      IDX_PORT_A_LATCH: rd = read_mux(dir_a_r, lat_a_r, pa_s) & MASK_A;
      IDX_PORT_B_LATCH: rd = read_mux(dir_b_r, lat_b_r, pb_s) & MASK_B;
      IDX_PORT_C_LATCH: rd = read_mux(dir_c_r, lat_c_r, pc_s) & MASK_C;
      IDX_PORT_D_LATCH: rd = read_mux(dir_d_r, lat_d_r, pd_s) & MASK_D;
      IDX_PORT_A_DIRECTION: rd = dir_a_r;
      IDX_PORT_B_DIRECTION: rd = dir_b_r;
      IDX_PORT_C_DIRECTION: rd = dir_c_r;
      IDX_PORT_D_DIRECTION: rd = dir_d_r;
      IDX_PORT_D_PULLUP_ENABLE: rd = pue_d_r;
      IDX_PORT_C_PULLUP_ENABLE: rd = pue_c_r;
      default: rd = 8'h00;
    endcase
  end

  always_comb begin
    lat_a_nxt = lat_a_r;
    lat_b_nxt = lat_b_r;
    lat_c_nxt = lat_c_r;
    lat_d_nxt = lat_d_r;
    dir_a_nxt = dir_a_r;
    dir_b_nxt = dir_b_r;
    dir_c_nxt = dir_c_r;
    dir_d_nxt = dir_d_r;
    pue_d_nxt = pue_d_r;
    pue_c_nxt = pue_c_r;
    ack_nxt = req;
    dat_nxt = (req & ~we_i) ? {24'h000000, rd} : 32'h00000000;
    if (wr) begin
      case (idx)
        IDX_PORT_A_LATCH: lat_a_nxt = merge(lat_a_r, wd, MASK_A);
        IDX_PORT_B_LATCH: lat_b_nxt = merge(lat_b_r, wd, MASK_B);
        IDX_PORT_C_LATCH: lat_c_nxt = merge(lat_c_r, wd, MASK_C);
        IDX_PORT_D_LATCH: lat_d_nxt = merge(lat_d_r, wd, MASK_D);
        IDX_PORT_A_DIRECTION: dir_a_nxt = wd & MASK_A;
        IDX_PORT_B_DIRECTION: dir_b_nxt = wd & MASK_B;
        IDX_PORT_C_DIRECTION: dir_c_nxt = wd & MASK_C;
        IDX_PORT_D_DIRECTION: dir_d_nxt = wd & MASK_D;
        IDX_PORT_D_PULLUP_ENABLE: pue_d_nxt = wd & MASK_D;
        IDX_PORT_C_PULLUP_ENABLE: pue_c_nxt = wd & MASK_C;
        default: ;
      endcase
    end
  end

  // Latches start unknown; pins stay quiet as direction resets to input
  always_ff @(posedge clk_i) begin
    lat_a_r <= lat_a_nxt & MASK_A;
    lat_b_r <= lat_b_nxt & MASK_B;
    lat_c_r <= lat_c_nxt & MASK_C;
    lat_d_r <= lat_d_nxt & MASK_D;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_a_r <= DIRECTION_RESET;
      dir_b_r <= DIRECTION_RESET;
      dir_c_r <= DIRECTION_RESET;
      dir_d_r <= DIRECTION_RESET;
      pue_d_r <= PULLUP_RESET;
      pue_c_r <= PULLUP_RESET;
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      dir_a_r <= dir_a_nxt;
      dir_b_r <= dir_b_nxt;
      dir_c_r <= dir_c_nxt;
      dir_d_r <= dir_d_nxt;
      pue_d_r <= pue_d_nxt;
      pue_c_r <= pue_c_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // Ownership of shared port D pins
  logic [D_W-1:0] spi_own;
  logic [D_W-1:0] tim_own;
  logic [D_W-1:0] d_gpio_o;
  logic [D_W-1:0] d_gpio_oe_n;

  always_comb begin
    spi_own = '0;
    tim_own = '0;
    spi_own[D_SPI_HI:D_SPI_LO] = {4{serial_if_enable_i}};
    spi_own[D_SS_BIT] = serial_if_enable_i & ~serial_if_master_select_i;
    tim_own[D_TIM_HI:D_TIM_LO] = timer_edge_level_hi_i | timer_edge_level_lo_i;
  end

  assign d_gpio_o = lat_d_r[D_W-1:0] & dir_d_r[D_W-1:0];
  assign d_gpio_oe_n = ~dir_d_r[D_W-1:0];

  always_comb begin
    port_d_pin_o = d_gpio_o;
    port_d_pin_oe_n_o = d_gpio_oe_n;
    for (int i = D_SPI_LO; i <= D_SPI_HI; i++) begin
      if (spi_own[i]) begin
        port_d_pin_o[i] = serial_if_pin_out_i[i];
        port_d_pin_oe_n_o[i] = serial_if_pin_oe_n_i[i];
      end
    end
    for (int i = D_TIM_LO; i <= D_TIM_HI; i++) begin
      if (tim_own[i]) begin
        port_d_pin_o[i] = timer_pin_out_i[i-D_TIM_LO];
        port_d_pin_oe_n_o[i] = timer_pin_oe_n_i[i-D_TIM_LO];
      end
    end
  end

  // port B bit 0 never steers slave select
  assign serial_if_pin_in_o = pd_s[D_SPI_HI:D_SPI_LO];
  assign timer_pin_in_o = pd_s[D_TIM_HI:D_TIM_LO];

  assign port_a_pin_o = lat_a_r[A_W-1:0] & dir_a_r[A_W-1:0];
  assign port_a_pin_oe_n_o = ~dir_a_r[A_W-1:0];
  assign port_b_pin_o = lat_b_r[B_W-1:0] & dir_b_r[B_W-1:0];
  assign port_b_pin_oe_n_o = ~dir_b_r[B_W-1:0];
  assign port_c_pin_o = lat_c_r[C_W-1:0] & dir_c_r[C_W-1:0];
  assign port_c_pin_oe_n_o = ~dir_c_r[C_W-1:0];
  assign port_c_pullup_o = pue_c_r[C_W-1:0] & ~dir_c_r[C_W-1:0];
  assign port_d_pullup_o = pue_d_r[D_W-1:0] & ~dir_d_r[D_W-1:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_DIR_RESET: assert property (disable iff (1'b0)
    rst_i |=> (dir_a_r == 8'h00 && dir_b_r == 8'h00 && dir_c_r == 8'h00 && dir_d_r == 8'h00))
    else $error("direction not cleared by reset");
  AST_DECODE_DIR_A: assert property (
    (req && we_i && sel_i[0] && idx == IDX_PORT_A_DIRECTION) |=> (dir_a_r == ($past(wd) & 8'h0f)))
    else $error("direction A write lost");
  AST_UPPER_ZERO: assert property (
    (req && !we_i && idx <= IDX_PORT_D_LATCH) |=> (ack_o && dat_o[7] == 1'b0 && dat_o[31:8] == 24'h0))
    else $error("unimplemented bits not zero");
  AST_C_DIR: assert property (
    $changed(dir_c_r) |-> (port_c_pin_oe_n_o == ~dir_c_r[1:0]))
    else $error("port C direction wrong");
  AST_C_PULLUP: assert property (
    (dir_c_r[0]) |-> !port_c_pullup_o[0])
    else $error("port C pullup on output");
  AST_TIMER: assert property (
    (timer_edge_level_hi_i[0] || timer_edge_level_lo_i[0]) |-> (port_d_pin_oe_n_o[4] == timer_pin_oe_n_i[0]))
    else $error("timer pin not routed");
  AST_SPI_OFF: assert property (
    !serial_if_enable_i |-> (port_d_pin_oe_n_o[3:0] == ~dir_d_r[3:0]))
    else $error("serial pins not released");
  AST_SS_MASTER: assert property (
    (serial_if_enable_i && serial_if_master_select_i) |-> (port_d_pin_oe_n_o[0] == ~dir_d_r[0]))
    else $error("slave select not released in master");
  AST_SPI_DIR: assert property (
    serial_if_enable_i |-> (port_d_pin_oe_n_o[3:1] == serial_if_pin_oe_n_i[3:1]))
    else $error("serial pin direction not from serial");
  AST_READ_D: assert property (
    (req && !we_i && idx == IDX_PORT_D_LATCH) |=>
      ({1'b0, dat_o[6:0]} == ((($past(dir_d_r) & $past(lat_d_r)) |
        (~$past(dir_d_r) & $past(pd_s))) & 8'h7f)))
    else $error("port D read source wrong");
  AST_PULLUP_D: assert property (
    (pue_d_r[2] && !dir_d_r[2]) |-> port_d_pullup_o[2] ##1 (!dir_d_r[2] || !port_d_pullup_o[2]))
    else $error("port D pullup gating wrong");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack held more than one cycle");

  COV_READ_D: cover property (req && !we_i && idx == IDX_PORT_D_LATCH ##1 ack_o);
  COV_SPI_MASTER: cover property (serial_if_enable_i && serial_if_master_select_i);
  COV_TIMER: cover property (timer_edge_level_hi_i[1] && !timer_pin_oe_n_i[1]);
endmodule : gpio_ports
`default_nettype wire

// ===== test/pin_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pin_far_side #(
  parameter int W = 1
) (
  input wire logic [W-1:0] oe_n_i,
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] pu_i,
  input wire logic [W-1:0] ext_i,
  output logic [W-1:0] lvl_o
);
  // Undriven pin goes to its pullup, else to the outside level
  always_comb begin
    for (int b = 0; b < W; b++) begin
      lvl_o[b] = !oe_n_i[b] ? drv_i[b] : (pu_i[b] ? 1'b1 : ext_i[b]);
    end
  end
endmodule : pin_far_side
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpio_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, sen, smst;
  logic [7:0] adr, q, dir, pue, pu;
  logic [3:0] sel, s_o, s_oe, s_in;
  logic [31:0] dw, dr;
  logic [A_W-1:0] a_l, a_o, a_oe;
  logic [B_W-1:0] b_l, b_o, b_oe;
  logic [C_W-1:0] c_l, c_o, c_oe, c_pu;
  logic [D_W-1:0] d_l, d_o, d_oe, d_pu;
  logic [1:0] thi, tlo, t_o, t_oe, t_in, tow;
  logic [7:0] ext [4];
  logic [7:0] lat [4];
  logic [7:0] po [4];
  logic [7:0] oe [4];
  logic [7:0] pul [4];
  int num_errors, num_checks;

  gpio_ports dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o(ack),
    .port_a_pin_i(a_l), .port_a_pin_o(a_o), .port_a_pin_oe_n_o(a_oe),
    .port_b_pin_i(b_l), .port_b_pin_o(b_o), .port_b_pin_oe_n_o(b_oe),
    .port_c_pin_i(c_l), .port_c_pin_o(c_o), .port_c_pin_oe_n_o(c_oe), .port_c_pullup_o(c_pu),
    .port_d_pin_i(d_l), .port_d_pin_o(d_o), .port_d_pin_oe_n_o(d_oe), .port_d_pullup_o(d_pu),
    .serial_if_enable_i(sen), .serial_if_master_select_i(smst), .serial_if_pin_out_i(s_o),
    .serial_if_pin_oe_n_i(s_oe), .serial_if_pin_in_o(s_in),
    .timer_edge_level_hi_i(thi), .timer_edge_level_lo_i(tlo), .timer_pin_out_i(t_o),
    .timer_pin_oe_n_i(t_oe), .timer_pin_in_o(t_in));
  pin_far_side #(.W(A_W)) fa (.oe_n_i(a_oe), .drv_i(a_o), .pu_i('0), .ext_i(ext[0][A_W-1:0]),
    .lvl_o(a_l));
  pin_far_side #(.W(B_W)) fb (.oe_n_i(b_oe), .drv_i(b_o), .pu_i('0), .ext_i(ext[1][B_W-1:0]),
    .lvl_o(b_l));
  pin_far_side #(.W(C_W)) fc (.oe_n_i(c_oe), .drv_i(c_o), .pu_i(c_pu), .ext_i(ext[2][C_W-1:0]),
    .lvl_o(c_l));
  pin_far_side #(.W(D_W)) fd (.oe_n_i(d_oe), .drv_i(d_o), .pu_i(d_pu), .ext_i(ext[3][D_W-1:0]),
    .lvl_o(d_l));

  always_comb begin
    po = '{8'(a_o), 8'(b_o), 8'(c_o), 8'(d_o)};
    oe = '{8'(a_oe), 8'(b_oe), 8'(c_oe), 8'(d_oe)};
    pul = '{8'h00, 8'h00, 8'(c_pu), 8'(d_pu)};
  end

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [7:0] msk(input int p);
    case (p)
      0: return 8'((1 << A_W) - 1);
      1: return 8'((1 << B_W) - 1);
      2: return 8'((1 << C_W) - 1);
      default: return 8'((1 << D_W) - 1);
    endcase
  endfunction : msk

  // Output bits read the latch, input bits the pin
  function automatic logic [7:0] rd_exp(input logic [7:0] l, d, e, u, m);
    return ((l & d) | (((e & ~u) | u) & ~d)) & m;
  endfunction : rd_exp

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'h1;
    dw <= {24'h0, d};
    // Ack and read data are taken at the same rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      chk(8'(ack), 8'h01);
      finish_test();
    end
    r = dr[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  initial begin
    q = 8'($urandom(11343));
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, dw, sen, smst, s_o, s_oe, thi, tlo, t_o, t_oe} = 0;
    for (int p = 0; p < 4; p++) ext[p] = 8'h00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      wb(1'b0, 6'(4 + p), 8'h00, q);
      chk(q, 8'h00);
      chk(oe[p], msk(p));
    end
    wb(1'b0, 6'h3f, 8'h00, q);
    chk(q, 8'h00);
    $display("test reset_and_map done");
    for (int i = 0; i < 30; i++) begin
      for (int p = 0; p < 4; p++) begin
        lat[p] = 8'($urandom);
        dir = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
        pue = 8'($urandom);
        ext[p] <= 8'($urandom);
        wb(1'b1, 6'(p), lat[p], q);
        wb(1'b1, 6'(4 + p), dir, q);
        if (p > 1) wb(1'b1, 6'(11 - p), pue, q);
        pu = (p > 1) ? (pue & ~dir & msk(p)) : 8'h00;
        wb(1'b0, 6'(4 + p), 8'h00, q);
        chk(q, dir & msk(p));
        repeat (3) @(posedge clk_i);
        wb(1'b0, 6'(p), 8'h00, q);
        chk(q, rd_exp(lat[p], dir, ext[p], pu, msk(p)));
        chk(po[p], lat[p] & dir & msk(p));
        chk(oe[p], ~dir & msk(p));
        chk(pul[p], pu);
      end
    end
    $display("test random_ports done");
    wb(1'b1, 6'h08, 8'h00, q);
    wb(1'b1, 6'h07, 8'h0f, q);
    wb(1'b1, 6'h05, 8'h01, q);
    sen <= 1'b1;
    s_oe <= 4'b1011;
    s_o <= 4'b0110;
    repeat (3) @(posedge clk_i);
    chk(8'(d_oe[3:0]), 8'h0b);
    chk(8'(d_o[2]), 8'h01);
    chk(8'(d_oe[0]), 8'h01);
    chk({4'h0, s_in}, {4'h0, ext[3][3], 1'b1, ext[3][1:0]});
    wb(1'b0, 6'h03, 8'h00, q);
    chk(q, rd_exp(lat[3], 8'h0f, ext[3], 8'h00, 8'h7f));
    smst <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(8'(d_oe[3:0]), 8'h0a);
    sen <= 1'b0;
    smst <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(8'(d_oe[3:0]), 8'h00);
    chk({4'h0, d_o[3:0]}, {4'h0, lat[3][3:0]});
    $display("test serial_share done");
    for (int e = 0; e < 16; e++) begin
      {thi, tlo} <= 4'(e);
      t_oe <= 2'($urandom);
      t_o <= 2'($urandom);
      // Three edges so the pin level has passed the synchroniser
      repeat (3) @(posedge clk_i);
      tow = thi | tlo;
      chk({6'h00, d_oe[5:4]}, {6'h00, (tow & t_oe) | ~tow});
      chk({6'h00, d_o[5:4]}, {6'h00, tow & t_o});
      chk({6'h00, t_in}, {6'h00, (tow & ~t_oe & t_o) | (~(tow & ~t_oe) & ext[3][5:4])});
    end
    {thi, tlo} <= 4'h0;
    $display("test timer_share done");
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      wb(1'b0, 6'(4 + p), 8'h00, q);
      chk(q, 8'h00);
      wb(1'b1, 6'(4 + p), 8'hff, q);
      wb(1'b0, 6'(p), 8'h00, q);
      chk(q, lat[p] & msk(p));
    end
    $display("test latch_keep done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
